// file: ccd_defs.svh
// Offsets, field positions, reset values and timing counts of the clock divider block
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CCD_CDC_OFS 4'h0
`define CCD_XOC_OFS 4'h4

// ****************************************
// Clock divider control fields
// ****************************************
`define CCD_SPD_RESTORE_BIT 15
`define CCD_SLOW_RATIO_MSB 14
`define CCD_SLOW_RATIO_LSB 12
`define CCD_SLOW_EN_BIT 11
`define CCD_RC_POST_MSB 10
`define CCD_RC_POST_LSB 8
`define CCD_CPU_POST_MSB 7
`define CCD_CPU_POST_LSB 6
`define CCD_PLL_KEEP_BIT 5
`define CCD_CDC_RESET 16'h3000
`define CCD_CDC_LO_WMASK 8'hE0
`define CCD_SLOW_RATIO_RESET 3'h3

// ****************************************
// Crystal oscillator control fields
// ****************************************
`define CCD_XOC_MAN_BIT 0
`define CCD_XOC_RUN_BIT 1
`define CCD_XOC_RDY_BIT 2
`define CCD_XOC_LOWP_BIT 3
`define CCD_XOC_DIG_BIT 4

// ****************************************
// Oscillator selection codes that need the PLL
// ****************************************
`define CCD_PLL_SEL_A 3'h3
`define CCD_PLL_SEL_B 3'h1

// ****************************************
// Timing
// ****************************************
`define CCD_CLK_KHZ 100000
`define CCD_XOSC_START_MS 1000
`define CCD_XOSC_START_CYC (`CCD_XOSC_START_MS * `CCD_CLK_KHZ)

`endif

// file: ccd_pkg.sv
// Types of the clock divider block
`default_nettype none
package ccd_pkg;

    typedef struct packed {
        logic [15:0] cdc;
        logic man;
        logic [1:0] sel_s;
        logic [1:0] drv_s;
        logic ack;
        logic [31:0] rdata;
        logic [31:0] start_cnt;
        logic rdy;
        logic run;
        logic pll;
        logic lowp;
        logic dig;
        logic wr_seen;
        logic [2:0] eff;
        logic [1:0] cpd;
        logic [7:0] cgap;
        logic [3:0] pgap;
    } ccd_state_t;

endpackage : ccd_pkg
`default_nettype wire

// file: ccd_divider.sv
// Power-of-two enable divider with restart on ratio change
`default_nettype none
module ccd_divider #(
    parameter int unsigned CW = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic en,
    input wire logic [CW-1:0] code,
    output logic out
);
    localparam int unsigned NW = (1 << CW) - 1;

    typedef struct packed {
        logic [NW-1:0] cnt;
        logic [CW-1:0] code;
    } ccd_div_t;

    ccd_div_t s_q;
    ccd_div_t s_d;
    logic [NW-1:0] mask;
    logic [NW-1:0] cur;

    always_comb begin
        s_d = s_q;
        mask = NW'((1 << code) - 1);
        // Ratio change restarts the count so the next pulse spacing is exact
        cur = (code != s_q.code) ? '0 : s_q.cnt;
        out = en && ((cur & mask) == mask);
        s_d.code = code;
        s_d.cnt = en ? NW'(cur + 1'b1) : cur;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    out_needs_en_a: assert property (out |-> en) else $error("divider pulse without input enable");
    unity_pass_a: assert property ((code == '0) && en |-> out) else $error("ratio 1 dropped a pulse");

endmodule : ccd_divider
`default_nettype wire

// file: ccd_top.sv
// Clock divider, doze control and crystal oscillator control with Avalon-MM registers
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`include "ccd_defs.svh"
`default_nettype none

// Behaviour
// - Doze ratio codes 000 to 111 give CPU to peripheral ratios 1:1, 1:2, 1:4 up to 1:128.
// - The doze ratio field resets to 011, a 1:8 ratio.
// - The ratio applies only while the slowdown enable bit 11 is set, otherwise the ratio is 1:1.
// - Peripherals keep their bits 7:6 post-scaled rate during doze and every CPU tick lines up with a peripheral tick.
// - With bit 15 set an interrupt restores full CPU speed, with it clear interrupts leave doze alone.
// - The PLL runs always when keep-running is set, otherwise only for selection codes 011 or 001.
// - Any module request starts the crystal oscillator without software.
// - Software can start the crystal oscillator early through its manual start bit.
// - The crystal oscillator may run only when the pin select configuration bit is 1.
// - With the pin select configuration bit 0 the oscillator pins go to digital I/O.
// - The drive level configuration bit picks low-power drive when 0, high drive by default.
module ccd_top #(
    parameter int unsigned NUM_REQ = 4,
    parameter int unsigned START_CYCLES = `CCD_XOSC_START_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic INTERRUPT_EVENT,
    input wire logic [2:0] OSC_SELECT,
    input wire logic [NUM_REQ-1:0] MODULE_XOSC_REQ,
    input wire logic CFG_XOSC_PIN_SELECT,
    input wire logic CFG_XOSC_DRIVE_LEVEL,
    output logic PERIPH_CLK_EN,
    output logic CPU_CLK_EN,
    output logic [2:0] INTERNAL_RC_POSTSCALE,
    output logic PLL_RUN,
    output logic CRYSTAL_OSC_RUN,
    output logic CRYSTAL_OSC_READY,
    output logic CRYSTAL_OSC_LOW_POWER,
    output logic CRYSTAL_OSC_PINS_DIGITAL
);
    ccd_pkg::ccd_state_t s_q;
    ccd_pkg::ccd_state_t s_d;
    logic hit_cdc;
    logic hit_xoc;
    logic wr;
    logic fuse_sel;
    logic [2:0] eff_code;
    logic [1:0] cpu_code;
    logic [7:0] cgap_cur;
    logic [3:0] pgap_cur;

    // ****************************************
    // Clock enables
    // ****************************************
    assign cpu_code = s_q.cdc[`CCD_CPU_POST_MSB:`CCD_CPU_POST_LSB];
    // Ratio forced to 1:1 while slowdown is off
    assign eff_code = s_q.cdc[`CCD_SLOW_EN_BIT] ?
        s_q.cdc[`CCD_SLOW_RATIO_MSB:`CCD_SLOW_RATIO_LSB] : 3'h0;

    ccd_divider #(.CW(2)) u_post (
        .clk(CLK),
        .reset_n(RESET_N),
        .en(1'b1),
        .code(cpu_code),
        .out(PERIPH_CLK_EN)
    );

    // CPU count advances on peripheral ticks only, keeping both domains aligned
    ccd_divider #(.CW(3)) u_doze (
        .clk(CLK),
        .reset_n(RESET_N),
        .en(PERIPH_CLK_EN),
        .code(eff_code),
        .out(CPU_CLK_EN)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        hit_cdc = AVS_ADDRESS == `CCD_CDC_OFS;
        hit_xoc = AVS_ADDRESS == `CCD_XOC_OFS;
        wr = AVS_WRITE && s_q.ack;
        fuse_sel = s_q.sel_s[1];
        // Config bits come from another domain
        s_d.sel_s = {s_q.sel_s[0], CFG_XOSC_PIN_SELECT};
        s_d.drv_s = {s_q.drv_s[0], CFG_XOSC_DRIVE_LEVEL};

        // One wait cycle per access; read data prepared in the first cycle
        s_d.ack = (AVS_READ || AVS_WRITE) && !s_q.ack;
        if (AVS_READ && !s_q.ack) begin
            s_d.rdata = 32'h0;
            if (hit_cdc) begin
                s_d.rdata[15:0] = s_q.cdc;
            end else if (hit_xoc) begin
                s_d.rdata[`CCD_XOC_MAN_BIT] = s_q.man;
                s_d.rdata[`CCD_XOC_RUN_BIT] = s_q.run;
                s_d.rdata[`CCD_XOC_RDY_BIT] = s_q.rdy;
                s_d.rdata[`CCD_XOC_LOWP_BIT] = s_q.lowp;
                s_d.rdata[`CCD_XOC_DIG_BIT] = s_q.dig;
            end
        end
        if (wr && hit_cdc) begin
            if (AVS_BYTEENABLE[0]) begin
                s_d.cdc[7:0] = AVS_WRITEDATA[7:0] & `CCD_CDC_LO_WMASK;
            end
            if (AVS_BYTEENABLE[1]) begin
                s_d.cdc[15:8] = AVS_WRITEDATA[15:8];
                s_d.wr_seen = 1'b1;
            end
        end
        if (wr && hit_xoc && AVS_BYTEENABLE[0]) begin
            s_d.man = AVS_WRITEDATA[`CCD_XOC_MAN_BIT];
        end
        // Hardware clear beats a same-cycle software set so the interrupt is never lost
        if (INTERRUPT_EVENT && s_q.cdc[`CCD_SPD_RESTORE_BIT]) begin
            s_d.cdc[`CCD_SLOW_EN_BIT] = 1'b0;
        end

        s_d.pll = s_q.cdc[`CCD_PLL_KEEP_BIT] ||
            (OSC_SELECT == `CCD_PLL_SEL_A) || (OSC_SELECT == `CCD_PLL_SEL_B);
        s_d.run = fuse_sel && (s_q.man || (|MODULE_XOSC_REQ));
        s_d.dig = !fuse_sel;
        s_d.lowp = !s_q.drv_s[1];

        // Ready flags the end of the worst-case start-up time
        if (!s_q.run) begin
            s_d.start_cnt = 32'h0;
            s_d.rdy = 1'b0;
        end else if (s_q.start_cnt >= 32'(START_CYCLES - 1)) begin
            s_d.rdy = 1'b1;
        end else begin
            s_d.start_cnt = s_q.start_cnt + 32'h1;
        end

        // Tick spacing trackers watched by the checks below
        s_d.eff = eff_code;
        s_d.cpd = cpu_code;
        cgap_cur = (eff_code != s_q.eff) ? 8'h0 : s_q.cgap;
        pgap_cur = (cpu_code != s_q.cpd) ? 4'h0 : s_q.pgap;
        s_d.cgap = CPU_CLK_EN ? 8'h0 : (PERIPH_CLK_EN ? 8'(cgap_cur + 8'h1) : cgap_cur);
        s_d.pgap = PERIPH_CLK_EN ? 4'h0 : 4'(pgap_cur + 4'h1);
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
            s_q.cdc <= `CCD_CDC_RESET;
            s_q.dig <= 1'b1;
            // Synchroniser starts at high drive so low power does not blip after reset
            s_q.drv_s <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign AVS_READDATA = s_q.rdata;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s_q.ack;
    assign INTERNAL_RC_POSTSCALE = s_q.cdc[`CCD_RC_POST_MSB:`CCD_RC_POST_LSB];
    assign PLL_RUN = s_q.pll;
    assign CRYSTAL_OSC_RUN = s_q.run;
    assign CRYSTAL_OSC_READY = s_q.rdy;
    assign CRYSTAL_OSC_LOW_POWER = s_q.lowp;
    assign CRYSTAL_OSC_PINS_DIGITAL = s_q.dig;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence restore_req_s;
        INTERRUPT_EVENT && s_q.cdc[`CCD_SPD_RESTORE_BIT] && s_q.cdc[`CCD_SLOW_EN_BIT];
    endsequence

    // Ratio falls to 1:1 in the very cycle the enable bit reads clear
    sequence full_speed_s;
        !s_q.cdc[`CCD_SLOW_EN_BIT] && (CPU_CLK_EN == PERIPH_CLK_EN);
    endsequence

    doze_ratio_a: assert property (CPU_CLK_EN |-> cgap_cur == 8'((1 << eff_code) - 1))
        else $error("CPU tick spacing does not match doze ratio");
    ratio_reset_a: assert property (!s_q.wr_seen |->
        s_q.cdc[`CCD_SLOW_RATIO_MSB:`CCD_SLOW_RATIO_LSB] == `CCD_SLOW_RATIO_RESET)
        else $error("doze ratio not at reset default");
    doze_off_a: assert property (!s_q.cdc[`CCD_SLOW_EN_BIT] |-> CPU_CLK_EN == PERIPH_CLK_EN)
        else $error("CPU slowed while slowdown disabled");
    tick_align_a: assert property (CPU_CLK_EN |-> PERIPH_CLK_EN)
        else $error("CPU tick outside a peripheral tick");
    irq_restore_a: assert property (restore_req_s |=> full_speed_s)
        else $error("interrupt did not restore full speed");
    irq_ignored_a: assert property (!s_q.cdc[`CCD_SPD_RESTORE_BIT] && !wr |=>
        $stable(s_q.cdc[`CCD_SLOW_EN_BIT]))
        else $error("interrupt changed doze while restore off");
    post_ratio_a: assert property (PERIPH_CLK_EN |-> pgap_cur == 4'((1 << cpu_code) - 1))
        else $error("peripheral tick spacing wrong");
    pll_keep_a: assert property (wr && hit_cdc && AVS_BYTEENABLE[0] &&
        AVS_WRITEDATA[`CCD_PLL_KEEP_BIT] ##1 s_q.cdc[`CCD_PLL_KEEP_BIT] |=> PLL_RUN)
        else $error("PLL stopped while keep-running set");
    osc_demand_a: assert property (fuse_sel && (|MODULE_XOSC_REQ) |=> CRYSTAL_OSC_RUN)
        else $error("module request did not start oscillator");
    osc_fuse_a: assert property (!fuse_sel |=> !CRYSTAL_OSC_RUN && CRYSTAL_OSC_PINS_DIGITAL)
        else $error("oscillator active with pins set to digital");
    bus_wait_a: assert property ((AVS_READ || AVS_WRITE) && !s_q.ack |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("access not answered after one wait cycle");

endmodule : ccd_top
`default_nettype wire

// file: ccd_top_tb.sv
// Self-checking testbench of the clock divider, doze and crystal oscillator control block
`include "ccd_defs.svh"
`default_nettype none
module ccd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned ST = 8;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic INTERRUPT_EVENT = 1'b0;
    logic CFG_XOSC_PIN_SELECT = 1'b1;
    logic CFG_XOSC_DRIVE_LEVEL = 1'b1;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic [3:0] AVS_BYTEENABLE = 4'h3;
    logic [3:0] MODULE_XOSC_REQ = 4'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [2:0] OSC_SELECT = 3'h0;
    logic [31:0] AVS_READDATA;
    logic [2:0] INTERNAL_RC_POSTSCALE;
    logic AVS_WAITREQUEST, PERIPH_CLK_EN, CPU_CLK_EN, PLL_RUN, CRYSTAL_OSC_RUN, CRYSTAL_OSC_READY;
    logic CRYSTAL_OSC_LOW_POWER, CRYSTAL_OSC_PINS_DIGITAL;
    int n_errors = 0;
    int samples_checked = 0;
    int n;
    logic [31:0] seed = 32'h00004EBD;
    logic [31:0] rd;
    logic [15:0] c;

    ccd_top #(.NUM_REQ(4), .START_CYCLES(ST)) u_dut (.CLK, .RESET_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_BYTEENABLE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .INTERRUPT_EVENT, .OSC_SELECT,
        .MODULE_XOSC_REQ, .CFG_XOSC_PIN_SELECT, .CFG_XOSC_DRIVE_LEVEL, .PERIPH_CLK_EN, .CPU_CLK_EN,
        .INTERNAL_RC_POSTSCALE, .PLL_RUN, .CRYSTAL_OSC_RUN, .CRYSTAL_OSC_READY, .CRYSTAL_OSC_LOW_POWER,
        .CRYSTAL_OSC_PINS_DIGITAL);

    initial begin
        forever #5 CLK = ~CLK;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Slowdown off forces the CPU ratio to 1:1
    function automatic int cpu_per(input logic [15:0] v);
        return (1 << v[7:6]) * (v[11] ? (1 << v[14:12]) : 1);
    endfunction : cpu_per

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    // Request held until waitrequest is seen low, released after that edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
        int t;
        t = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= wd;
        AVS_BYTEENABLE <= be;
        if (wr) AVS_WRITE <= 1'b1;
        else AVS_READ <= 1'b1;
        // Waitrequest and read data seen as they stand at the rising edge
        do begin
            @(posedge CLK);
            t++;
        end while (AVS_WAITREQUEST !== 1'b0 && t < 50);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        if (t >= 50) n_errors++;
    endtask : bus

    // Skips stale pulses left from before a code change, then counts one full period
    task automatic period(input logic cpu, output int p);
        repeat (3) begin
            p = 0;
            do begin
                @(negedge CLK);
                p++;
            end while ((cpu ? CPU_CLK_EN : PERIPH_CLK_EN) !== 1'b1 && p < 4000);
        end
    endtask : period

    task automatic settle(input int k);
        repeat (k) @(posedge CLK);
        @(negedge CLK);
    endtask : settle

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    always @(negedge CLK) begin
        if (RESET_N && CPU_CLK_EN === 1'b1) chk({31'h0, PERIPH_CLK_EN}, 32'h1);
    end

    initial begin
        repeat (100000) @(posedge CLK);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge CLK);
        RESET_N <= 1'b1;
        settle(3);
        chk({30'h0, CRYSTAL_OSC_LOW_POWER, CRYSTAL_OSC_PINS_DIGITAL}, 32'h0);
        bus(1'b0, `CCD_CDC_OFS, 32'h0, 4'h3);
        chk(rd, 32'h00003000);
        bus(1'b0, `CCD_XOC_OFS, 32'h0, 4'h3);
        chk(rd, 32'h0);
        bus(1'b1, 4'h8, 32'h0000FFFF, 4'hF);
        bus(1'b0, 4'h8, 32'h0, 4'h3);
        chk(rd, 32'h0);
        bus(1'b0, `CCD_CDC_OFS, 32'h0, 4'h3);
        chk(rd, 32'h00003000);
        $display("test reset and map done");
        for (int i = 0; i < 9; i++) begin
            seed = xs(seed);
            c = seed[15:0] & 16'h7FE0;
            if (i < 8) c[14:12] = i[2:0];
            c[11] = (i < 8);
            c[5] = i[0];
            bus(1'b1, `CCD_CDC_OFS, {16'h0, seed[31:16] & 16'h001F | c}, 4'h3);
            bus(1'b0, `CCD_CDC_OFS, 32'h0, 4'h3);
            chk(rd, {16'h0, c});
            chk({29'h0, INTERNAL_RC_POSTSCALE}, {29'h0, c[10:8]});
            period(1'b0, n);
            chk(n, 1 << c[7:6]);
            period(1'b1, n);
            chk(n, cpu_per(c));
            for (int s = 0; s < 8; s++) begin
                @(posedge CLK);
                OSC_SELECT <= s[2:0];
                settle(2);
                chk({31'h0, PLL_RUN}, {31'h0, c[5] | s == 3 | s == 1});
            end
        end
        bus(1'b1, `CCD_CDC_OFS, 32'h0000FFFF, 4'h1);
        bus(1'b0, `CCD_CDC_OFS, 32'h0, 4'h3);
        chk(rd, {16'h0, c[15:8], 8'hE0});
        $display("test ratios done");
        bus(1'b1, `CCD_CDC_OFS, 32'h00008800, 4'h3);
        @(posedge CLK);
        INTERRUPT_EVENT <= 1'b1;
        @(posedge CLK);
        INTERRUPT_EVENT <= 1'b0;
        bus(1'b0, `CCD_CDC_OFS, 32'h0, 4'h3);
        chk(rd, 32'h00008000);
        bus(1'b1, `CCD_CDC_OFS, 32'h00003800, 4'h3);
        @(posedge CLK);
        INTERRUPT_EVENT <= 1'b1;
        @(posedge CLK);
        INTERRUPT_EVENT <= 1'b0;
        bus(1'b0, `CCD_CDC_OFS, 32'h0, 4'h3);
        chk(rd, 32'h00003800);
        period(1'b1, n);
        chk(n, 8);
        $display("test interrupt done");
        seed = xs(seed);
        @(posedge CLK);
        MODULE_XOSC_REQ <= 4'h1 << seed[1:0];
        settle(2);
        chk({30'h0, CRYSTAL_OSC_RUN, CRYSTAL_OSC_READY}, 32'h2);
        settle(ST - 2);
        chk({31'h0, CRYSTAL_OSC_READY}, 32'h0);
        settle(1);
        chk({31'h0, CRYSTAL_OSC_READY}, 32'h1);
        @(posedge CLK);
        MODULE_XOSC_REQ <= 4'h0;
        settle(3);
        chk({30'h0, CRYSTAL_OSC_RUN, CRYSTAL_OSC_READY}, 32'h0);
        bus(1'b1, `CCD_XOC_OFS, 32'h1, 4'h3);
        bus(1'b0, `CCD_XOC_OFS, 32'h0, 4'h3);
        chk(rd, 32'h3);
        CFG_XOSC_PIN_SELECT <= 1'b0;
        CFG_XOSC_DRIVE_LEVEL <= 1'b0;
        settle(5);
        chk({31'h0, CRYSTAL_OSC_RUN}, 32'h0);
        chk({31'h0, CRYSTAL_OSC_PINS_DIGITAL}, 32'h1);
        chk({31'h0, CRYSTAL_OSC_LOW_POWER}, 32'h1);
        $display("test crystal done");
        finish_test();
    end
endmodule : ccd_top_tb
`default_nettype wire
